//--- emb_bus.sv
// external memory bus interface: option registers, request buffer and
// the pin sequencer for address, segment, data and strobe lines.
// assumes the core register file port and the request port run on clk;
// byte lane reads arrive from the pins and are synchronised.
`timescale 1ns/1ps
`include "emb_consts.svh"

// Contract
// - standard style: read/write line high on reads, low on writes
// - read/write line set at cycle start, held until next cycle
// - read/write line floats on bus acknowledge or core float request
// - strobe style 1: data strobe acts normally on reads, stays high on writes
// - strobe style 1: read/write high on reads, strobe timing on writes
// - toggle off or protection on: strobe, read/write and data pins move only on external accesses
// - toggle on, protection off: pins move on internal too, except data strobe and, in style 1, read/write
// - separate bus 0 multiplexes address low byte; 1 floats during address
// - bus float bit floats strobe, read/write, data, address and segment pins
// - address bus always driven; only the float bit releases it
// - segment bus always driven; only the float bit releases it
// - option one bit 0 reads 1; option two bit 7 reads 0
// - segment save bit resets to 0 and alters interrupt entry
// - page swap bit exchanges page and port registers; clears at reset
// - wait insert adds program or data wait count chosen by segment top bit
// - program stretch lengthens address strobe 0..3 cycles, segments 0..1Fh
// - data stretch lengthens address strobe, segments 20h..3Fh
// - wait counts add 0..7 cycles each and reset to seven
// - address phase then data phase; strobe low only on external accesses
// - data strobe stays high for whole internal cycle
// - segment save set: interrupt entry pushes and return restores segment
module emb_bus #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // register file port
    input  wire logic            reg_wr_en,
    input  wire logic            reg_rd_en,
    input  wire logic [7:0]      reg_idx,
    input  wire logic [7:0]      reg_wdata,
    output logic      [7:0]      reg_rdata,
    // wait counts and status from the core
    input  wire logic [2:0]      program_wait_count,
    input  wire logic [2:0]      data_wait_count,
    input  wire logic            core_float_request,
    input  wire logic            bus_ack,
    input  wire logic            mem_protect_en,
    // memory cycle requests
    input  wire logic            req_valid,
    output logic                 req_ready,
    input  wire emb_pkg::emb_req_t req_data,
    output logic                 rsp_valid,
    output logic      [7:0]      rsp_data,
    // option levels to the core
    output logic                 segment_save_on_irq,
    output logic                 page_reg_swap,
    // pins
    output logic      [15:0]     addr_bus_o,
    output logic                 addr_bus_oe_n,
    output logic      [5:0]      segment_bus_high_o,
    output logic                 segment_bus_high_oe_n,
    input  wire logic [7:0]      byte_lane_i,
    output logic      [7:0]      byte_lane_o,
    output logic                 byte_lane_oe_n,
    output logic                 address_strobe_line,
    output logic                 data_strobe_line_o,
    output logic                 data_strobe_line_oe_n,
    output logic                 read_not_write_line_o,
    output logic                 read_not_write_line_oe_n
);
    import emb_pkg::*;

    // picks the program or the data figure by the segment top bit
    function automatic logic [2:0] pick3(input logic seg_top, input logic [2:0] prog, input logic [2:0] dat);
        pick3 = seg_top ? dat : prog;
    endfunction : pick3

    // option registers, stored bits only
    logic [7:0]  opt1_reg;
    logic [7:0]  opt2_reg;
    logic [7:0]  reg_rdata_reg;

    emb_state_t  state_reg;
    emb_state_t  state_next;
    emb_req_t    cur_reg;
    emb_cfg_t    cfg_reg;

    logic [15:0] addr_reg;
    logic [5:0]  seg_reg;
    logic [7:0]  dat_reg;
    logic        dat_drive_reg;
    logic        asn_reg;
    logic        dsn_reg;
    logic        rwn_reg;
    logic        rsp_valid_reg;
    logic [7:0]  rsp_data_reg;
    logic [7:0]  lane_sync1_reg;
    logic [7:0]  lane_sync2_reg;

    // ---------------- register file ----------------
    wire hit1   = (reg_idx == `EMB_OPT1_IDX);
    wire hit2   = (reg_idx == `EMB_OPT2_IDX);
    wire wr1    = reg_wr_en && hit1;
    wire wr2    = reg_wr_en && hit2;

    // reserved bits 7 and 4 of option one are not stored and read as 0
    wire [7:0] opt1_mask  = (8'h01 << `EMB_O1_STYLE) | (8'h01 << `EMB_O1_STROBE2)
                          | (8'h01 << `EMB_O1_SEPBUS) | (8'h01 << `EMB_O1_TOGGLE)
                          | (8'h01 << `EMB_O1_FLOAT);
    wire [7:0] opt2_mask  = `EMB_O2_MASK;
    wire [7:0] opt1_view  = (opt1_reg & opt1_mask) | (8'h01 << `EMB_O1_FIXED1);
    wire [7:0] opt2_view  = opt2_reg & opt2_mask;
    wire [7:0] rd_sel     = hit1 ? opt1_view : (hit2 ? opt2_view : 8'h00);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            opt1_reg <= `EMB_OPT1_RST;
            opt2_reg <= `EMB_OPT2_RST;
        end
        else
        begin
            if (wr1)
                opt1_reg <= reg_wdata & opt1_mask;
            if (wr2)
                opt2_reg <= reg_wdata & opt2_mask;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata_reg <= 8'h00;
        else if (reg_rd_en)
            reg_rdata_reg <= rd_sel;
    end

    assign reg_rdata           = reg_rdata_reg;
    assign segment_save_on_irq = opt2_reg[`EMB_O2_SEGSAVE];
    assign page_reg_swap       = opt2_reg[`EMB_O2_SWAP];

    // ---------------- request buffer ----------------
    logic     fifo_valid;
    emb_req_t fifo_data;
    wire      take = (state_reg == ST_IDLE) && fifo_valid;

    emb_fifo #(
        .WIDTH ($bits(emb_req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (req_data),
        .out_valid (fifo_valid),
        .out_ready (take),
        .out_data  (fifo_data)
    );

    // options frozen when a cycle starts; a write mid-cycle waits for the next one
    emb_cfg_t cfg_live;
    assign cfg_live.style     = opt1_reg[`EMB_O1_STYLE];
    assign cfg_live.sepbus    = opt1_reg[`EMB_O1_SEPBUS];
    assign cfg_live.toggle    = opt1_reg[`EMB_O1_TOGGLE];
    assign cfg_live.float_all = opt1_reg[`EMB_O1_FLOAT];
    assign cfg_live.waitsel   = opt2_reg[`EMB_O2_WAITSEL];
    assign cfg_live.pstr      = opt2_reg[`EMB_O2_PSTR_LO +: 2];
    assign cfg_live.dstr      = opt2_reg[`EMB_O2_DSTR_LO +: 2];
    assign cfg_live.pwait     = program_wait_count;
    assign cfg_live.dwait     = data_wait_count;
    assign cfg_live.protect   = mem_protect_en;

    // ---------------- phase timing ----------------
    wire       seg_top_new = fifo_data.seg[`EMB_SEG_TOP];
    wire [2:0] stretch_new = pick3(seg_top_new, {1'b0, cfg_live.pstr}, {1'b0, cfg_live.dstr});
    wire [2:0] wait_sel    = pick3(cur_reg.seg[`EMB_SEG_TOP], cfg_reg.pwait, cfg_reg.dwait);
    wire [2:0] wait_cnt    = cfg_reg.waitsel ? wait_sel : `EMB_ZERO_CNT;

    wire ext      = !cur_reg.internal;
    wire active   = ext || (cfg_reg.toggle && !cfg_reg.protect);
    wire in_addr  = (state_reg == ST_ADDR);
    wire in_data  = (state_reg == ST_DATA);
    wire cnt_done;

    wire       leave_data = in_data && cnt_done;
    wire       ext_read   = ext && !cur_reg.write;
    wire       cnt_load   = take || (in_addr && cnt_done) || (leave_data && ext_read);
    wire [2:0] cnt_val    = take ? stretch_new : (in_addr ? wait_cnt : `EMB_SYNC_LAT);

    emb_cnt #(
        .WIDTH (3)
    ) u_cnt (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (cnt_load),
        .load_val (cnt_val),
        .done     (cnt_done)
    );

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (fifo_valid)
                    state_next = ST_ADDR;
            ST_ADDR:
                if (cnt_done)
                    state_next = ST_DATA;
            ST_DATA:
                if (cnt_done)
                    state_next = ext_read ? ST_CAP : ST_IDLE;
            ST_CAP:
                if (cnt_done)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur_reg <= '0;
            cfg_reg <= {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, `EMB_STR_RST, `EMB_STR_RST, `EMB_WAIT_RST, `EMB_WAIT_RST, 1'b0};
        end
        else if (take)
        begin
            cur_reg <= fifo_data;
            cfg_reg <= cfg_live;
        end
    end

    // ---------------- pin decode ----------------
    // strobe low only in the data phase of an external access; style 1 keeps it high on writes
    wire dsn_low   = ext && in_data && (!cfg_reg.style || !cur_reg.write);
    wire dsn_next  = !dsn_low;
    wire asn_next  = !(active && in_addr);

    // standard style: level set once per cycle and held; style 1: write enable
    wire rwn_std   = (active && in_addr) ? !cur_reg.write : rwn_reg;
    wire rwn_we    = !(ext && cur_reg.write && in_data);
    wire rwn_next  = cfg_reg.style ? rwn_we : rwn_std;

    // data lanes: address low byte in the address phase unless separate bus
    wire dat_addr  = active && in_addr;
    wire dat_wr    = active && in_data && cur_reg.write;
    wire dat_rd    = active && in_data && !cur_reg.write;
    wire [7:0] dat_next = dat_addr ? cur_reg.addr[7:0] : (dat_wr ? cur_reg.wdata : dat_reg);
    wire dat_drive_next = dat_addr ? !cfg_reg.sepbus
                        : (dat_wr ? 1'b1 : (dat_rd ? 1'b0 : dat_drive_reg));

    // address and segment buses follow every cycle start regardless of toggle
    wire addr_load = in_addr && (state_next == ST_DATA || !cnt_done);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            addr_reg      <= 16'h0000;
            seg_reg       <= 6'h00;
            dat_reg       <= 8'h00;
            dat_drive_reg <= 1'b0;
            asn_reg       <= 1'b1;
            dsn_reg       <= 1'b1;
            rwn_reg       <= 1'b1;
        end
        else
        begin
            if (addr_load)
            begin
                addr_reg <= cur_reg.addr;
                seg_reg  <= cur_reg.seg;
            end
            dat_reg       <= dat_next;
            dat_drive_reg <= dat_drive_next;
            asn_reg       <= asn_next;
            dsn_reg       <= dsn_next;
            rwn_reg       <= rwn_next;
        end
    end

    // float controls act on the registered pins; the core float request
    // releases only the strobe and read/write lines; bus acknowledge also releases the data lanes
    wire strobe_float = cfg_reg.float_all || core_float_request || bus_ack;

    assign addr_bus_o               = addr_reg;
    assign addr_bus_oe_n            = cfg_reg.float_all;
    assign segment_bus_high_o       = seg_reg;
    assign segment_bus_high_oe_n    = cfg_reg.float_all;
    assign byte_lane_o              = dat_reg;
    assign byte_lane_oe_n           = !dat_drive_reg || cfg_reg.float_all || bus_ack;
    assign address_strobe_line      = asn_reg;
    assign data_strobe_line_o       = dsn_reg;
    assign data_strobe_line_oe_n    = strobe_float;
    assign read_not_write_line_o    = rwn_reg;
    assign read_not_write_line_oe_n = strobe_float;

    // ---------------- read capture ----------------
    // lanes are pin inputs; two flops before use, so the answer trails the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lane_sync1_reg <= 8'h00;
            lane_sync2_reg <= 8'h00;
        end
        else
        begin
            lane_sync1_reg <= byte_lane_i;
            lane_sync2_reg <= lane_sync1_reg;
        end
    end

    wire cap_done = (state_reg == ST_CAP) && cnt_done;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= 8'h00;
        end
        else
        begin
            rsp_valid_reg <= cap_done;
            if (cap_done)
                rsp_data_reg <= lane_sync2_reg;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_data  = rsp_data_reg;
endmodule : emb_bus

//--- emb_consts.svh
// constants for the external memory bus interface: register indices,
// bit positions, reset values and small timing counts.
// assumes inclusion by bare name from design files only.
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// register file indices of the two option registers
`define EMB_OPT1_IDX      8'hF5
`define EMB_OPT2_IDX      8'hF6

// option register one bit positions
`define EMB_O1_FIXED1     0
`define EMB_O1_FLOAT      1
`define EMB_O1_TOGGLE     2
`define EMB_O1_SEPBUS     3
`define EMB_O1_STROBE2    5
`define EMB_O1_STYLE      6

// option register two bit positions
`define EMB_O2_DSTR_LO    0
`define EMB_O2_PSTR_LO    2
`define EMB_O2_WAITSEL    4
`define EMB_O2_SWAP       5
`define EMB_O2_SEGSAVE    6

// reset values
`define EMB_OPT1_RST      8'h01
`define EMB_OPT2_RST      8'h0F
`define EMB_WAIT_RST      3'h7
`define EMB_STR_RST       2'h3
`define EMB_O2_MASK       8'h7F

// top segment bit picks the program or the data figures
`define EMB_SEG_TOP       5

// cycles spent after the data strobe before the read byte leaves the synchroniser
`define EMB_SYNC_LAT      3'h2
`define EMB_ZERO_CNT      3'h0

`endif

//--- emb_pkg.sv
// types shared by the external memory bus interface files.
// assumes nothing beyond a SystemVerilog compiler.
package emb_pkg;

    // one memory cycle as issued by the core
    typedef struct packed {
        logic        write;
        logic        internal;
        logic [5:0]  seg;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emb_req_t;

    // option settings frozen at the start of each memory cycle
    typedef struct packed {
        logic        style;
        logic        sepbus;
        logic        toggle;
        logic        float_all;
        logic        waitsel;
        logic [1:0]  pstr;
        logic [1:0]  dstr;
        logic [2:0]  pwait;
        logic [2:0]  dwait;
        logic        protect;
    } emb_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_CAP  = 2'b11
    } emb_state_t;

endpackage : emb_pkg

//--- emb_fifo.sv
// request buffer between the core and the bus sequencer.
// assumes a single clock; the output word is held in a register.
`timescale 1ns/1ps
module emb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("emb_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;

    wire mem_empty = (wr_ptr_reg == rd_ptr_reg);
    wire mem_full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire push      = in_valid && !mem_full;
    wire load_out  = !mem_empty && (!out_valid_reg || out_ready);

    assign in_ready  = !mem_full;
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (load_out)
            begin
                rd_ptr_reg    <= rd_ptr_reg + 1'b1;
                out_data_reg  <= mem_reg[rd_ptr_reg[AW-1:0]];
                out_valid_reg <= 1'b1;
            end
            else if (out_ready)
                out_valid_reg <= 1'b0;
        end
    end
endmodule : emb_fifo

//--- emb_cnt.sv
// loadable down counter that times phase lengths of a memory cycle.
// assumes load and the count value come from logic on the same clock.
`timescale 1ns/1ps
module emb_cnt #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic                  done
);
    initial
    begin
        if (WIDTH < 2)
            $error("emb_cnt: width must be at least 2");
    end

    logic [WIDTH-1:0] cnt_reg;

    assign done = (cnt_reg == '0);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else if (load)
            cnt_reg <= load_val;
        else if (!done)
            cnt_reg <= cnt_reg - 1'b1;
    end
endmodule : emb_cnt

//--- emb_bus_properties.sv
// checker for the external memory bus interface pins and registers.
// assumes it is bound onto emb_bus and sees only that module's ports.
`timescale 1ns/1ps
module emb_bus_properties (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_idx,
    input wire logic [7:0] reg_rdata,
    input wire logic       core_float_request,
    input wire logic       bus_ack,
    input wire logic       rsp_valid,
    input wire logic       segment_save_on_irq,
    input wire logic       page_reg_swap,
    input wire logic       addr_bus_oe_n,
    input wire logic       segment_bus_high_oe_n,
    input wire logic       byte_lane_oe_n,
    input wire logic       data_strobe_line_o,
    input wire logic       data_strobe_line_oe_n,
    input wire logic       read_not_write_line_o,
    input wire logic       read_not_write_line_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // end of a driven read strobe
    sequence s_read_strobe;
        (!data_strobe_line_o && !data_strobe_line_oe_n && read_not_write_line_o) ##1 data_strobe_line_o;
    endsequence

    AST_RWN_FLOAT: assert property ((core_float_request || bus_ack) |-> read_not_write_line_oe_n)
        else $error("read/write line driven during a float request");
    AST_DS_FLOAT: assert property ((core_float_request || bus_ack) |-> data_strobe_line_oe_n)
        else $error("data strobe driven during a float request");
    AST_OPT1_FIXED: assert property (reg_rd_en && reg_idx == 8'hF5 |=> reg_rdata[0] && !reg_rdata[7])
        else $error("option one fixed bits read wrong");
    AST_OPT2_TOP: assert property (reg_rd_en && reg_idx == 8'hF6 |=> !reg_rdata[7])
        else $error("option two top bit reads one");
    AST_RDATA_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("register read data moved without a read");
    AST_BUS_FLOAT: assert property (addr_bus_oe_n == segment_bus_high_oe_n)
        else $error("address and segment buses float apart");
    AST_FLOAT_ALL: assert property (addr_bus_oe_n |-> data_strobe_line_oe_n && read_not_write_line_oe_n
                                    && byte_lane_oe_n)
        else $error("a memory pin is driven while the bus floats");
    AST_READ_ANSWER: assert property (s_read_strobe |-> ##2 rsp_valid)
        else $error("read strobe gave no answer");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid [*4])
        else $error("answers closer than one memory cycle");
    AST_OPT_RESET: assert property ($fell(sys_rst) |-> !segment_save_on_irq && !page_reg_swap)
        else $error("option two levels not cleared by reset");
endmodule : emb_bus_properties

bind emb_bus emb_bus_properties u_props (.*);

//--- emb_mem_model.sv
// behavioural byte-wide external memory chip on the emb_bus pins.
// assumes the bench resolves floated strobes to their pull-up level.
`timescale 1ns/1ps
module emb_mem_model (
    input wire logic        clk,
    input wire logic        we_style,
    input wire logic [15:0] addr,
    input wire logic        ds_n,
    input wire logic        read_not_write_line,
    input wire logic [7:0]  din,
    output logic     [7:0]  dout
);
    logic [7:0] mem [0:255];
    wire        read_en = !ds_n && read_not_write_line;

    initial dout = 8'hA5;
    always @(posedge ds_n)
        if (!we_style && !read_not_write_line)
            mem[addr[7:0]] <= din;
    // write-enable style: the read/write line itself is the strobe
    always @(posedge read_not_write_line)
        if (we_style && ds_n)
            mem[addr[7:0]] <= din;
    // a released lane never keeps the old byte, so a late sample shows up
    always @(negedge clk)
        dout <= read_en ? mem[addr[7:0]] : ~dout;
endmodule : emb_mem_model

//--- emb_bus_bench.sv
// self-checking bench for emb_bus with an external memory model.
// assumes emb_pkg, emb_bus, its sub-blocks and emb_mem_model are compiled first.
`timescale 1ns/1ps
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin mismatches++; \
    $display("Error at %0t: got %h, expected %h", $time, got, want); end end
module emb_bus_bench;
    import emb_pkg::*;
    logic        clk, sys_rst, reg_wr_en, reg_rd_en, core_float_request, bus_ack, mem_protect_en;
    logic        req_valid, we_style, rd_tk, req_ready, rsp_valid, segment_save_on_irq, page_reg_swap;
    logic        addr_bus_oe_n, segment_bus_high_oe_n, byte_lane_oe_n, address_strobe_line;
    logic        data_strobe_line_o, data_strobe_line_oe_n, read_not_write_line_o, read_not_write_line_oe_n;
    logic [7:0]  reg_idx, reg_wdata, reg_rdata, rsp_data, byte_lane_o, mdout;
    logic [2:0]  program_wait_count, data_wait_count;
    logic [15:0] addr_bus_o;
    logic [5:0]  segment_bus_high_o;
    logic [31:0] seed = 32'hADB14F56;
    logic [31:0] r;
    logic [7:0]  rq[$], dq[$], wd[0:7];
    logic [7:0]  exp_b;
    emb_req_t    req_data;
    int          mismatches = 0, checks_done = 0, cyc = 0;
    wire logic [7:0] byte_lane_i = byte_lane_oe_n ? mdout : byte_lane_o;

    emb_bus #(.FIFO_DEPTH(8)) dut (.*);
    emb_mem_model u_mem (.clk(clk), .we_style(we_style), .addr(addr_bus_o), .din(byte_lane_o), .dout(mdout),
                         .ds_n(data_strobe_line_oe_n | data_strobe_line_o),
                         .read_not_write_line(read_not_write_line_oe_n | read_not_write_line_o));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1;
        reg_idx = i;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 0;
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        @(negedge clk);
        reg_rd_en = 1;
        reg_idx = i;
        rq.push_back(e);
        @(negedge clk);
        reg_rd_en = 0;
    endtask : rd

    // held until accepted; a full buffer simply stalls the caller
    task automatic req(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [5:0] s);
        req_valid = 1;
        req_data = {w, 1'b0, s, a, d};
        while (req_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
    endtask : req

    task automatic settle(input logic v);
        for (int k = 0; k < 80 && addr_bus_oe_n !== v; k++)
            @(negedge clk);
    endtask : settle

    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        rd_tk <= reg_rd_en;
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    always @(negedge clk)
    begin
        // the compare macro names its expectation twice, so pop into a variable first
        if (rd_tk === 1'b1)
        begin
            exp_b = rq.pop_front();
            `CHK(reg_rdata, exp_b)
        end
        if (rsp_valid === 1'b1)
        begin
            exp_b = dq.pop_front();
            `CHK(rsp_data, exp_b)
        end
    end

    initial
    begin
        {sys_rst, reg_wr_en, reg_rd_en, req_valid, core_float_request, bus_ack, mem_protect_en, we_style} = 8'h80;
        {reg_idx, reg_wdata, program_wait_count, data_wait_count, req_data} = '0;
        repeat (4) @(negedge clk);
        sys_rst = 0;
        rd(8'hF5, 8'h01);
        rd(8'hF6, 8'h0F);
        rd(8'h10, 8'h00);
        // second strobe and toggle bits stay clear
        repeat (3)
        begin
            r = rnd();
            wr(8'hF5, r[7:0] & 8'hDB);
            rd(8'hF5, (r[7:0] & 8'h4A) | 8'h01);
            wr(8'hF6, r[15:8]);
            rd(8'hF6, r[15:8] & 8'h7F);
        end
        // both strobe styles, with and without the multiplexed lane
        for (int s = 0; s < 4; s++)
        begin
            r = rnd();
            wr(8'hF5, {1'b0, s[1], 2'b00, s[0], 3'b001});
            wr(8'hF6, {3'b000, r[4:0]});
            program_wait_count = r[7:5];
            data_wait_count = r[10:8];
            mem_protect_en = r[11];
            we_style = s[1];
            for (int i = 0; i < 6; i++)
            begin
                r = rnd();
                wd[i] = r[23:16];
                req(1'b1, {r[15:8], 3'b000, s[1:0], i[2:0]}, r[23:16], r[29:24]);
            end
            for (int i = 0; i < 6; i++)
            begin
                r = rnd();
                dq.push_back(wd[i]);
                req(1'b0, {r[15:8], 3'b000, s[1:0], i[2:0]}, r[23:16], r[29:24]);
            end
            req_valid = 0;
            while (dq.size() != 0)
                @(negedge clk);
        end
        wr(8'hF5, 8'h0B);
        req(1'b1, 16'h1234, 8'h5A, 6'h01);
        req_valid = 0;
        settle(1'b1);
        `CHK(addr_bus_oe_n, 1'b1)
        wr(8'hF5, 8'h09);
        req(1'b1, 16'h1235, 8'hA5, 6'h21);
        req_valid = 0;
        settle(1'b0);
        core_float_request = 1;
        repeat (2) @(negedge clk);
        `CHK(read_not_write_line_oe_n, 1'b1)
        core_float_request = 0;
        bus_ack = 1;
        repeat (2) @(negedge clk);
        `CHK(data_strobe_line_oe_n, 1'b1)
        bus_ack = 0;
        `CHK(addr_bus_o, 16'h1235)
        `CHK(segment_bus_high_o, 6'h21)
        wr(8'hF6, 8'h60);
        `CHK(segment_save_on_irq, 1'b1)
        `CHK(page_reg_swap, 1'b1)
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        `CHK(segment_save_on_irq, 1'b0)
        `CHK(page_reg_swap, 1'b0)
        `CHK(address_strobe_line, 1'b1)
        rd(8'hF5, 8'h01);
        rd(8'hF6, 8'h0F);
        repeat (3) @(negedge clk);
        wrap_up();
    end
endmodule : emb_bus_bench
